// ### rtl/sdram_pkg.sv
/*
 Shared constants for the SDRAM command decoder and burst column generator:
 command encodings, mode field positions, codes, timing and geometry.
 Assumes a single 20 MHz clock domain and a controller that drives commands.
*/
package sdram_pkg;
	localparam int ROW_BITS = 12;
	localparam int COL_BITS = 9;
	localparam int BANK_BITS = 2;
	localparam int MODE_BITS = 12;
	// Command code is {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n}.
	localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
	localparam logic [3:0] CMD_REFRESH = 4'h1;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_ACTIVE = 4'h3;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_TERMINATE = 4'h6;
	localparam logic [3:0] CMD_NOP = 4'h7;
	// Mode register field positions.
	localparam int BL_LSB = 0;
	localparam int ORDER_BIT = 3;
	localparam int LAT_LSB = 4;
	localparam int OPMODE_LSB = 7;
	localparam int WBURST_BIT = 9;
	localparam int AUTO_PRE_BIT = 10;
	localparam logic [2:0] BL_ONE = 3'h0;
	localparam logic [2:0] BL_TWO = 3'h1;
	localparam logic [2:0] BL_FOUR = 3'h2;
	localparam logic [2:0] BL_EIGHT = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam logic [2:0] LAT_TWO = 3'h2;
	localparam logic [2:0] LAT_THREE = 3'h3;
	localparam logic [MODE_BITS-1:0] MODE_RESET = 12'h000;
	// Start-up wait: 100 us at 50 ns is 2000 cycles.
	localparam int STARTUP_US = 100;
	localparam int CLK_NS = 50;
	localparam int STARTUP_CYCLES = (STARTUP_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int REFRESH_NEEDED = 2;
endpackage

// ### rtl/burst_column.sv
/*
 Burst column generator: given the start column, beat count, length code and
 order bit, gives the column of the current beat. Purely combinational.
 Assumes the caller holds its inputs stable for the beat.
*/
`timescale 1ns/1ns
module burst_column #(
	parameter int COLS = 9
) (
	input wire logic [COLS-1:0] start,
	input wire logic [COLS-1:0] beat,
	input wire logic [2:0] length_code,
	input wire logic interleave,
	output logic [COLS-1:0] column
);
	logic [COLS-1:0] mask;
	logic [COLS-1:0] offset;
	// The mask marks the low bits that move inside the block; upper bits stay fixed.
	always_comb begin
		case (length_code)
			sdram_pkg::BL_TWO: mask = 9'h001;
			sdram_pkg::BL_FOUR: mask = 9'h003;
			sdram_pkg::BL_EIGHT: mask = 9'h007;
			sdram_pkg::BL_PAGE: mask = 9'h1FF;
			default: mask = 9'h000;
		endcase
		// Whole page ignores interleave since the order is not defined there.
		if (interleave && length_code != sdram_pkg::BL_PAGE)
			offset = start ^ beat;
		else
			offset = start + beat;
		column = (start & ~mask) | (offset & mask);
	end
endmodule

// ### rtl/sdram_core.sv
/*
 SDRAM device command logic: start-up tracking, mode register, bank rows,
 burst column sequencing, auto precharge and read latency timing.
 Assumes commands are synchronous to CLOCK; NRST stands in for power-up.
*/
`timescale 1ns/1ns
// How it works
// - Access needs open row, then burst.
// - Active takes bank and twelve-bit row.
// - Read or write takes nine-bit start column.
// - Four banks, 4096 rows, 512 sixteen-bit columns.
// - Lengths 1,2,4,8,page plus burst terminate.
// - Auto precharge closes row after burst.
// - New column accepted every cycle.
// - Mode register loaded before operational commands.
// - Mode register holds until rewritten.
// - Mode fields: length, order, latency, mode, write.
// - Burst length caps locations per command.
// - Page bursts only with sequential order.
// - Upper column bits pick the burst block.
// - Fixed bursts wrap within their block.
// - Page bursts wrap within the row.
// - Order bit: sequential or interleaved.
// - Read drives at n+m-1, valid n+m.
// - Write burst bit forces single writes.
module sdram_core #(
	parameter int STARTUP = sdram_pkg::STARTUP_CYCLES
) (
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic [3:0] COMMAND,
	input wire logic [1:0] BANK,
	input wire logic [11:0] ADDRESS,
	output logic [1:0] ACCESS_BANK,
	output logic [11:0] ACCESS_ROW,
	output logic [8:0] ACCESS_COLUMN,
	output logic ACCESS_VALID,
	output logic ACCESS_WRITE,
	output logic DATA_DRIVE,
	output logic DATA_VALID,
	output logic READY,
	output logic [3:0] ROWS_OPEN
);
	typedef enum logic [1:0] {WAITING, PRECHARGED, REFRESHED, RUNNING} phase_t;
	typedef struct packed {
		phase_t phase;
		logic [11:0] wait_count;
		logic [1:0] refreshes;
		logic [11:0] mode;
		logic [3:0] open;
		logic [3:0][11:0] rows;
		logic burst;
		logic burst_write;
		logic burst_pre;
		logic [1:0] bank;
		logic [8:0] start;
		logic [8:0] beat;
		logic [9:0] length;
		logic [1:0] read_pipe;
		logic [1:0] acc_bank;
		logic [11:0] acc_row;
		logic [8:0] acc_col;
		logic acc_valid;
		logic acc_write;
		logic drive;
		logic valid;
		logic ready;
	} state_t;
	state_t s, next_s;
	logic [8:0] col_now;
	logic [8:0] col_start;
	logic [2:0] bl_code;
	logic [9:0] bl_words;
	logic is_rw;
	logic fire;
	assign bl_code = s.mode[sdram_pkg::BL_LSB +: 3];
	assign is_rw = (COMMAND == sdram_pkg::CMD_READ) || (COMMAND == sdram_pkg::CMD_WRITE);

	// Column of the beat in flight, and of a fresh command's first beat.
	burst_column #(.COLS(9)) i_burst_column (
		.start(s.start),
		.beat(s.beat),
		.length_code(bl_code),
		.interleave(s.mode[sdram_pkg::ORDER_BIT]),
		.column(col_now)
	);
	assign col_start = ADDRESS[8:0];

	// Beats per burst from the length code; reserved codes act as one beat.
	always_comb begin
		case (bl_code)
			sdram_pkg::BL_TWO: bl_words = 10'h002;
			sdram_pkg::BL_FOUR: bl_words = 10'h004;
			sdram_pkg::BL_EIGHT: bl_words = 10'h008;
			sdram_pkg::BL_PAGE: bl_words = 10'h200;
			default: bl_words = 10'h001;
		endcase
	end

	// Read and write only act once the open rows and start-up phase allow them.
	assign fire = is_rw && s.phase == RUNNING && s.open[BANK];

	// All next-state logic: start-up phases, mode, rows, burst and read timing.
	always_comb begin
		next_s = s;
		next_s.acc_valid = 1'b0;
		next_s.read_pipe = {s.read_pipe[0], 1'b0};
		if (s.wait_count != 12'h000)
			next_s.wait_count = s.wait_count - 12'h001;
		// A running burst steps one column per cycle until its length is used.
		if (s.burst) begin
			next_s.acc_valid = 1'b1;
			next_s.acc_bank = s.bank;
			next_s.acc_row = s.rows[s.bank];
			next_s.acc_col = col_now;
			next_s.acc_write = s.burst_write;
			if (!s.burst_write)
				next_s.read_pipe[0] = 1'b1;
			next_s.beat = s.beat + 9'h001;
			if ({1'b0, s.beat} + 10'h001 >= s.length) begin
				next_s.burst = 1'b0;
				if (s.burst_pre)
					next_s.open[s.bank] = 1'b0;
			end
		end
		case (COMMAND)
			sdram_pkg::CMD_PRECHARGE: begin
				if (s.phase == WAITING && s.wait_count == 12'h000)
					next_s.phase = PRECHARGED;
				if (ADDRESS[sdram_pkg::AUTO_PRE_BIT])
					next_s.open = 4'h0;
				else
					next_s.open[BANK] = 1'b0;
				if (s.burst && (ADDRESS[sdram_pkg::AUTO_PRE_BIT] || BANK == s.bank))
					next_s.burst = 1'b0;
			end
			sdram_pkg::CMD_REFRESH: begin
				if (s.phase == PRECHARGED && s.open == 4'h0) begin
					next_s.refreshes = s.refreshes + 2'h1;
					if (s.refreshes + 2'h1 == 2'(sdram_pkg::REFRESH_NEEDED))
						next_s.phase = REFRESHED;
				end
			end
			sdram_pkg::CMD_LOAD_MODE: begin
				// Load is ignored with a row open, since the result is undefined then.
				if (s.open == 4'h0 && s.phase != WAITING && s.phase != PRECHARGED) begin
					next_s.mode = ADDRESS;
					next_s.phase = RUNNING;
				end
			end
			sdram_pkg::CMD_ACTIVE: begin
				if (s.phase == RUNNING && !s.open[BANK]) begin
					next_s.open[BANK] = 1'b1;
					next_s.rows[BANK] = ADDRESS;
				end
			end
			sdram_pkg::CMD_TERMINATE: next_s.burst = 1'b0;
			default: ;
		endcase
		// A new column command replaces any burst in flight at once.
		if (fire) begin
			next_s.burst = 1'b1;
			next_s.bank = BANK;
			next_s.start = col_start;
			next_s.beat = 9'h000;
			next_s.burst_write = COMMAND == sdram_pkg::CMD_WRITE;
			next_s.burst_pre = ADDRESS[sdram_pkg::AUTO_PRE_BIT];
			if (COMMAND == sdram_pkg::CMD_WRITE && s.mode[sdram_pkg::WBURST_BIT])
				next_s.length = 10'h001;
			else
				next_s.length = bl_words;
		end
		// First beat leaves at the next edge; latency two drives one edge early.
		if (s.mode[sdram_pkg::LAT_LSB +: 3] == sdram_pkg::LAT_THREE) begin
			next_s.drive = s.read_pipe[0];
			next_s.valid = s.read_pipe[1];
		end else begin
			next_s.drive = s.burst && !s.burst_write;
			next_s.valid = s.read_pipe[0];
		end
		// Ready has its own flop so that the port carries no decode logic.
		next_s.ready = next_s.phase == RUNNING;
	end

	// One register stage for all state; reset stands in for power-up.
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			s <= '0;
			s.phase <= WAITING;
			s.wait_count <= 12'(STARTUP);
			s.mode <= sdram_pkg::MODE_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign ACCESS_BANK = s.acc_bank;
	assign ACCESS_ROW = s.acc_row;
	assign ACCESS_COLUMN = s.acc_col;
	assign ACCESS_VALID = s.acc_valid;
	assign ACCESS_WRITE = s.acc_write;
	assign DATA_DRIVE = s.drive;
	assign DATA_VALID = s.valid;
	assign READY = s.ready;
	assign ROWS_OPEN = s.open;

	// Read data is valid one cycle after the pins start driving.
	drive_then_valid_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		s.valid |-> $past(s.drive)) else $error("valid without prior drive");
	// The burst starts one edge after the command and shows its first beat one edge later.
	first_column_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		fire && !s.burst |-> ##2 ACCESS_VALID && ACCESS_COLUMN == $past(ADDRESS[8:0], 2))
		else $error("first column wrong");
	// Active stores the row for its bank.
	row_store_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		COMMAND == sdram_pkg::CMD_ACTIVE && READY && !ROWS_OPEN[BANK]
		|=> ROWS_OPEN[$past(BANK)] && s.rows[$past(BANK)] == $past(ADDRESS))
		else $error("row not opened");
	// Columns stay in the block for a burst length of four.
	block_wrap_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		s.burst && bl_code == sdram_pkg::BL_FOUR |=> ACCESS_COLUMN[8:2] == $past(s.start[8:2]))
		else $error("burst left block");
	// Single write when the write burst bit is set; a command right behind it may restart.
	single_write_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		fire && COMMAND == sdram_pkg::CMD_WRITE && s.mode[sdram_pkg::WBURST_BIT] ##1 !fire
		|=> !s.burst) else $error("write burst not single");
	// Auto precharge closes the row at burst end.
	auto_close_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		s.burst && s.burst_pre && !next_s.burst && COMMAND == sdram_pkg::CMD_NOP
		|=> !ROWS_OPEN[$past(s.bank)]) else $error("auto precharge missed");
	// Mode register changes only on a load.
	mode_hold_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		COMMAND != sdram_pkg::CMD_LOAD_MODE |=> $stable(s.mode)) else $error("mode changed");
	// Terminate stops the burst.
	terminate_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		COMMAND == sdram_pkg::CMD_TERMINATE |=> !s.burst) else $error("burst not ended");
endmodule

// ### bench/cmd_drv.sv
/*
 Controller model for the SDRAM core: drives command, bank and address.
 Assumes the core registers commands on the rising clock edge.
*/
`timescale 1ns/1ns
module cmd_drv (
	input wire logic clock,
	output logic [3:0] command,
	output logic [1:0] bank,
	output logic [11:0] address
);
	// Start idle so that nothing is registered before the first request.
	initial begin
		command = sdram_pkg::CMD_NOP;
		bank = 2'h2;
		address = 12'h000;
	end
	// One command for one clock, always aimed at bank two.
	task automatic issue(input logic [3:0] cmd, input logic [11:0] adr);
		@(negedge clock);
		command <= cmd;
		bank <= 2'h2;
		address <= adr;
	endtask
	// The address is released here, so it shows the inverse of its last value.
	task automatic nop();
		@(negedge clock);
		command <= sdram_pkg::CMD_NOP;
		address <= ~address;
	endtask
	// Start-up: no-ops past the wait, close every bank, then the first refresh.
	task automatic start(input int wait_cycles);
		repeat (wait_cycles) nop();
		issue(sdram_pkg::CMD_PRECHARGE, 12'h400);
		issue(sdram_pkg::CMD_REFRESH, 12'h000);
	endtask
endmodule

// ### bench/sdram_core_test.sv
/*
 Testbench for the SDRAM core: start-up, mode loads, burst orders,
 latency and auto precharge. Assumes one 20 MHz clock and the cmd_drv model.
*/
`timescale 1ns/1ns
module sdram_core_test;
	localparam int STARTUP = 4;
	logic clock, nrst, acc_valid, acc_write, drive, dvalid, ready;
	logic [3:0] command, rows_open;
	logic [1:0] bank, acc_bank;
	logic [11:0] address, acc_row;
	logic [8:0] acc_col;
	logic [2:0] cb [4] = '{sdram_pkg::BL_EIGHT, sdram_pkg::BL_TWO, sdram_pkg::BL_ONE, 3'h3};
	logic ci [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	logic [8:0] cs [4] = '{9'h005, 9'h1FF, 9'h033, 9'h1FA};
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	cmd_drv i_cmd_drv (.clock(clock), .command(command), .bank(bank), .address(address));
	sdram_core #(.STARTUP(STARTUP)) i_sdram_core (.CLOCK(clock), .NRST(nrst),
		.COMMAND(command), .BANK(bank), .ADDRESS(address), .ACCESS_BANK(acc_bank),
		.ACCESS_ROW(acc_row), .ACCESS_COLUMN(acc_col), .ACCESS_VALID(acc_valid),
		.ACCESS_WRITE(acc_write), .DATA_DRIVE(drive), .DATA_VALID(dvalid),
		.READY(ready), .ROWS_OPEN(rows_open));
	// Free-running 50 ns clock.
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// The run needs under two hundred cycles, so this ceiling only catches a hang.
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	// Four-state comparison, so an unknown never passes.
	task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Single closing point for normal end and timeout.
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Column of beat i: wrap inside the block, or over the whole row for a page.
	function automatic logic [8:0] exp_col(logic [8:0] s, int i, logic [2:0] bl, logic il);
		logic [8:0] m;
		m = (bl == sdram_pkg::BL_PAGE) ? 9'h1FF : 9'((1 << bl) - 1);
		if (il && bl != sdram_pkg::BL_PAGE) return (s & ~m) | ((s ^ 9'(i)) & m);
		return (s & ~m) | ((s + 9'(i)) & m);
	endfunction
	// Normal operating mode with both reserved bits kept at zero.
	function automatic logic [11:0] mode(logic [2:0] bl, logic il, logic [2:0] lat, logic wb);
		return {2'h0, wb, 2'h0, lat, il, bl};
	endfunction
	// Close all rows, load a mode and open row 0xABC in bank two.
	task automatic setup(input logic [11:0] m);
		i_cmd_drv.issue(sdram_pkg::CMD_PRECHARGE, 12'h400);
		i_cmd_drv.issue(sdram_pkg::CMD_LOAD_MODE, m);
		i_cmd_drv.issue(sdram_pkg::CMD_ACTIVE, 12'hABC);
		i_cmd_drv.nop();
	endtask
	// Follow the beats of one access; a full fixed burst must then stop.
	task automatic burst(input logic [3:0] cmd, input logic [11:0] adr, input int n,
		input logic [2:0] bl, input logic il);
		int k;
		k = 0;
		i_cmd_drv.issue(cmd, adr);
		i_cmd_drv.nop();
		while (acc_valid !== 1'b1 && k < 4) begin
			i_cmd_drv.nop();
			k++;
		end
		check("bank", 12'h002, 12'(acc_bank));
		check("row", 12'hABC, acc_row);
		check("write", 12'(cmd == sdram_pkg::CMD_WRITE), 12'(acc_write));
		for (int i = 0; i < n; i++) begin
			check("valid", 12'h001, 12'(acc_valid));
			check("column", 12'(exp_col(adr[8:0], i, bl, il)), 12'(acc_col));
			i_cmd_drv.nop();
		end
		if (bl != sdram_pkg::BL_PAGE && n == (1 << bl)) check("end", 12'h0, 12'(acc_valid));
	endtask
	// Main sequence.
	initial begin
		nrst = 1'b0;
		repeat (20) @(negedge clock);
		check("ready", 12'h000, 12'(ready));
		nrst = 1'b1;
		i_cmd_drv.issue(sdram_pkg::CMD_ACTIVE, 12'hABC);
		i_cmd_drv.start(STARTUP + 2);
		i_cmd_drv.issue(sdram_pkg::CMD_LOAD_MODE, mode(3'h2, 1'b0, 3'h2, 1'b0));
		i_cmd_drv.nop();
		check("rows", 12'h000, 12'(rows_open));
		check("ready", 12'h000, 12'(ready));
		i_cmd_drv.issue(sdram_pkg::CMD_REFRESH, 12'h000);
		i_cmd_drv.issue(sdram_pkg::CMD_LOAD_MODE, mode(3'h2, 1'b0, 3'h2, 1'b0));
		i_cmd_drv.issue(sdram_pkg::CMD_ACTIVE, 12'hABC);
		i_cmd_drv.nop();
		check("ready", 12'h001, 12'(ready));
		check("rows", 12'h004, 12'(rows_open));
		burst(sdram_pkg::CMD_READ, 12'h005, 4, sdram_pkg::BL_FOUR, 1'b0);
		i_cmd_drv.issue(sdram_pkg::CMD_LOAD_MODE, mode(3'h3, 1'b0, 3'h2, 1'b0));
		burst(sdram_pkg::CMD_READ, 12'h00D, 4, sdram_pkg::BL_FOUR, 1'b0);
		for (int c = 0; c < 4; c++) begin
			setup(mode(cb[c], ci[c], sdram_pkg::LAT_TWO, 1'b0));
			burst(sdram_pkg::CMD_READ, {3'h0, cs[c]}, 1 << cb[c], cb[c], ci[c]);
		end
		setup(mode(sdram_pkg::BL_PAGE, 1'b1, sdram_pkg::LAT_TWO, 1'b0));
		burst(sdram_pkg::CMD_READ, 12'h1FE, 4, sdram_pkg::BL_PAGE, 1'b1);
		i_cmd_drv.issue(sdram_pkg::CMD_TERMINATE, 12'h000);
		repeat (3) i_cmd_drv.nop();
		check("stopped", 12'h000, 12'(acc_valid));
		setup(mode(sdram_pkg::BL_FOUR, 1'b0, sdram_pkg::LAT_TWO, 1'b1));
		burst(sdram_pkg::CMD_WRITE, 12'h008, 1, sdram_pkg::BL_ONE, 1'b0);
		burst(sdram_pkg::CMD_READ, 12'h408, 4, sdram_pkg::BL_FOUR, 1'b0);
		repeat (6) i_cmd_drv.nop();
		check("closed", 12'h000, 12'(rows_open));
		for (int m = 2; m < 4; m++) begin
			setup(mode(sdram_pkg::BL_ONE, 1'b0, 3'(m), 1'b0));
			i_cmd_drv.issue(sdram_pkg::CMD_READ, 12'h000);
			for (int k = 0; k <= m; k++) begin
				i_cmd_drv.nop();
				if (k < m) check("drive", 12'(k == m - 1), 12'(drive));
				check("data", 12'(k == m), 12'(dvalid));
			end
		end
		i_cmd_drv.issue(sdram_pkg::CMD_READ, 12'h010);
		i_cmd_drv.issue(sdram_pkg::CMD_READ, 12'h020);
		i_cmd_drv.nop();
		check("column", 12'h010, 12'(acc_col));
		i_cmd_drv.nop();
		check("column", 12'h020, 12'(acc_col));
		// Closing one bank alone ends its row, and a read to it is then refused.
		i_cmd_drv.issue(sdram_pkg::CMD_PRECHARGE, 12'h000);
		i_cmd_drv.nop();
		check("rows", 12'h000, 12'(rows_open));
		i_cmd_drv.issue(sdram_pkg::CMD_READ, 12'h030);
		repeat (2) i_cmd_drv.nop();
		check("refused", 12'h000, 12'(acc_valid));
		tally_and_finish();
	end
endmodule
